// ### spcp_pkg.sv
package spcp_pkg;
	// Word layout
	localparam int          SPCP_WORD_W     = 8;
	localparam int          SPCP_MODE_HI    = 7;
	localparam int          SPCP_MODE_LO    = 6;
	localparam int          SPCP_RANGE_BIT  = 5;
	localparam int          SPCP_MUTE_BIT   = 4;
	localparam int          SPCP_VOL_HI     = 3;
	localparam int          SPCP_VOL_LO     = 0;
	localparam logic [7:0]  SPCP_WORD_RST   = 8'h00;
	localparam logic [2:0]  SPCP_CNT_RST    = 3'h0;
	// Mode codes
	localparam logic [1:0]  SPCP_MODE_AUTO  = 2'h0;
	localparam logic [1:0]  SPCP_MODE_RX    = 2'h1;
	localparam logic [1:0]  SPCP_MODE_IDLE  = 2'h2;
	localparam logic [1:0]  SPCP_MODE_TX    = 2'h3;
	// Clear response time
	localparam int          SPCP_CLR_US     = 30;
	localparam int          SPCP_CLK_MHZ    = 40;
	localparam int          SPCP_CLR_CYC    = SPCP_CLR_US * SPCP_CLK_MHZ;
	// Synchroniser depth
	localparam int          SPCP_SYNC_N     = 2;
endpackage

// ### spcp_shift.sv
`timescale 1ns/1ps
// Link-side shift register on the serial clock
module spcp_shift
	import spcp_pkg::*;
(
	input  wire logic             i_sclk,
	input  wire logic             i_rst_n,
	input  wire logic             i_sdata,
	output logic [SPCP_WORD_W-1:0] o_word
);
	typedef struct packed {
		logic [SPCP_WORD_W-1:0] sr;
	} spcp_sh_t;
	spcp_sh_t st_q;
	spcp_sh_t st_d;

	// Shift MSB first, new bit enters at LSB
	always_comb begin
		st_d    = st_q;
		st_d.sr = {st_q.sr[SPCP_WORD_W-2:0], i_sdata}; // [RQ2] [RQ3]
	end

	always_ff @(posedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q.sr <= SPCP_WORD_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_word = st_q.sr;

	// Checked from the second serial edge on, so the history has a sampled value
	a_shift_msb: assert property (@(posedge i_sclk) disable iff (!i_rst_n) // [RQ2]
		##1 (o_word[SPCP_WORD_W-1:1] == $past(o_word[SPCP_WORD_W-2:0])))
		else $error("shift order wrong");
	a_shift_data: assert property (@(posedge i_sclk) disable iff (!i_rst_n) // [RQ3]
		##1 (o_word[0] == $past(i_sdata)))
		else $error("data not sampled on rising edge");
endmodule // spcp_shift

// ### spcp_port.sv
`timescale 1ns/1ps
// Contract
// RQ1: Host clocks at most 1.0 MHz; the bench host model clocks at 31.25 MHz (32 ns period)
// RQ2: Eight bit word, MSB first
// RQ3: Data sampled on serial clock rise
// RQ4: Strobe rise latches shifted word
// RQ5: Host drops strobe before next falling edge
// RQ6: Clock may run on if strobe early
// RQ7: Clear low zeroes all control bits
// RQ8: Power-up and disable force zero
// RQ9: Power-down high disables device outputs; the port keeps O_MID_SUPPLY_REFERENCE tied high
// RQ10: Bits 7:6 select switching mode
// RQ11: Bit 5 selects attenuator range
// RQ12: Bit 4 mutes microphone
// RQ13: Bits 3:0 receive volume, zero max
// RQ14: Zero held after clear until latch
// RQ15: Clear takes effect within 30 us
// RQ16: Held word separate from shift register
module spcp_port
	import spcp_pkg::*;
(
	input  wire logic       I_CLK,
	input  wire logic       I_RESETN,
	input  wire logic       I_SCLK,
	input  wire logic       I_SDATA,
	input  wire logic       I_WORD_LATCH_STROBE,
	input  wire logic       I_CLEAR_N,
	input  wire logic       I_POWER_DOWN_INPUT,
	output logic            O_ACTIVE,
	output logic [1:0]      O_MODE_SELECT,
	output logic            O_RANGE_SELECT,
	output logic            O_MIC_MUTE,
	output logic [3:0]      O_VOLUME_LEVEL,
	output logic            O_FORCE_RX,
	output logic            O_FORCE_IDLE,
	output logic            O_FORCE_TX,
	output logic            O_MID_SUPPLY_REFERENCE
);
	typedef struct packed {
		logic [SPCP_SYNC_N-1:0] stb_s;
		logic [SPCP_SYNC_N-1:0] clr_s;
		logic [SPCP_SYNC_N-1:0] pd_s;
		logic                   stb_prev;
		logic [SPCP_WORD_W-1:0] cap0;
		logic [SPCP_WORD_W-1:0] cap1;
		logic [SPCP_WORD_W-1:0] ctrl;
		logic                   active;
	} spcp_st_t;

	spcp_st_t               st_q;
	spcp_st_t               st_d;
	logic [SPCP_WORD_W-1:0] shift_word;
	logic                   stb_rise;
	logic                   zap;

	// Link-domain shifter, reset only by system reset so clear cannot glitch it
	spcp_shift u_shift (
		.i_sclk  (I_SCLK),
		.i_rst_n (I_RESETN),
		.i_sdata (I_SDATA),
		.o_word  (shift_word)
	);

	// Mode decode helper
	function automatic logic is_mode(input logic [SPCP_WORD_W-1:0] w, input logic [1:0] m);
		is_mode = (w[SPCP_MODE_HI:SPCP_MODE_LO] == m);
	endfunction

	// Strobe edge and clear condition on synchronised levels
	assign stb_rise = st_q.stb_s[1] & ~st_q.stb_prev;            // [RQ4]
	assign zap      = ~st_q.clr_s[1] | st_q.pd_s[1];             // [RQ7] [RQ8]

	// Next state
	always_comb begin
		st_d          = st_q;
		st_d.stb_s    = {st_q.stb_s[0], I_WORD_LATCH_STROBE};
		st_d.clr_s    = {st_q.clr_s[0], I_CLEAR_N};
		st_d.pd_s     = {st_q.pd_s[0], I_POWER_DOWN_INPUT};
		st_d.stb_prev = st_q.stb_s[1];
		// Shift word is stable while strobe high; double capture settles it
		st_d.cap0     = shift_word;                               // [RQ6]
		st_d.cap1     = st_q.cap0;
		if (zap) begin
			st_d.ctrl = SPCP_WORD_RST;                            // [RQ7] [RQ8] [RQ14] [RQ15]
		end else if (stb_rise) begin
			st_d.ctrl = st_q.cap1;                                // [RQ4] [RQ16]
		end
		st_d.active   = ~st_q.pd_s[1];                            // [RQ9]
	end

	// State register; strobe and clear syncs both reset low, so clear reads as asserted
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			st_q.stb_s    <= 2'h0;
			st_q.clr_s    <= 2'h0;
			st_q.pd_s     <= 2'h0;
			st_q.stb_prev <= 1'b0;
			st_q.cap0     <= SPCP_WORD_RST;
			st_q.cap1     <= SPCP_WORD_RST;
			st_q.ctrl     <= SPCP_WORD_RST;                       // [RQ8]
			st_q.active   <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// Field outputs from the held word
	assign O_MODE_SELECT          = st_q.ctrl[SPCP_MODE_HI:SPCP_MODE_LO]; // [RQ10]
	assign O_RANGE_SELECT         = st_q.ctrl[SPCP_RANGE_BIT];            // [RQ11]
	assign O_MIC_MUTE             = st_q.ctrl[SPCP_MUTE_BIT];             // [RQ12]
	assign O_VOLUME_LEVEL         = st_q.ctrl[SPCP_VOL_HI:SPCP_VOL_LO];   // [RQ13]
	assign O_FORCE_RX             = is_mode(st_q.ctrl, SPCP_MODE_RX);     // [RQ10]
	assign O_FORCE_IDLE           = is_mode(st_q.ctrl, SPCP_MODE_IDLE);   // [RQ10]
	assign O_FORCE_TX             = is_mode(st_q.ctrl, SPCP_MODE_TX);     // [RQ10]
	assign O_ACTIVE               = st_q.active;                          // [RQ9]
	assign O_MID_SUPPLY_REFERENCE = 1'b1;                                 // [RQ9]

	// Latch sequence: strobe rise seen with no clear or power-down pending
	sequence s_latch;
		stb_rise && !zap;
	endsequence

	a_latch_word: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		s_latch |=> st_q.ctrl == $past(st_q.cap1)) // [RQ4]
		else $error("strobe did not latch word");
	a_hold_word: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		!stb_rise && !zap |=> $stable(st_q.ctrl)) // [RQ16]
		else $error("control changed without strobe");
	a_clear_zero: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		!I_CLEAR_N ##1 !I_CLEAR_N ##1 !I_CLEAR_N |=> st_q.ctrl == SPCP_WORD_RST) // [RQ7] [RQ15]
		else $error("clear did not zero word");
	a_pd_zero: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		st_q.pd_s[1] |=> st_q.ctrl == SPCP_WORD_RST && !O_ACTIVE) // [RQ8] [RQ9]
		else $error("disable did not zero word");
	a_zero_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		st_q.ctrl == SPCP_WORD_RST && !stb_rise |=> st_q.ctrl == SPCP_WORD_RST) // [RQ14]
		else $error("word left zero without latch");
	a_mode_decode: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		$onehot0({O_FORCE_RX, O_FORCE_IDLE, O_FORCE_TX})
		&& (O_MODE_SELECT == SPCP_MODE_AUTO) == !(O_FORCE_RX | O_FORCE_IDLE | O_FORCE_TX)) // [RQ10]
		else $error("mode decode wrong");
	a_fields_map: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		{O_MODE_SELECT, O_RANGE_SELECT, O_MIC_MUTE, O_VOLUME_LEVEL} == st_q.ctrl) // [RQ11] [RQ12] [RQ13]
		else $error("field map wrong");
	a_active_pd: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		!I_POWER_DOWN_INPUT ##1 !I_POWER_DOWN_INPUT ##1 !I_POWER_DOWN_INPUT ##1 1 |=> O_ACTIVE) // [RQ9]
		else $error("device not active");
endmodule // spcp_port

// ### spcp_host.sv
`timescale 1ns/1ps
// Host controller model driving the three-wire port
module spcp_host (
	output logic o_sclk,
	output logic o_sdata,
	output logic o_strobe
);
	// Clock parked low between frames
	initial begin
		o_sclk = 1'b0;
		o_sdata = 1'b0;
		o_strobe = 1'b0;
	end
	// Shift one word, then latch it with the strobe; 32 ns serial period
	task automatic send(input logic [7:0] w);
		for (int k = 7; k >= 0; k--) begin
			o_sdata = w[k];
			#16 o_sclk = 1'b1;
			#16 o_sclk = 1'b0;
		end
		o_sdata = ~w[0]; // Stale data inverted
		#16 o_strobe = 1'b1;
		#250 o_strobe = 1'b0;
		#100;
	endtask
endmodule // spcp_host

// ### spcp_port_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the serial control port
module spcp_port_bench;
	import spcp_pkg::*;
	logic       clk;
	logic       rst_n;
	logic       sclk;
	logic       sdata;
	logic       strobe;
	logic       clear_n;
	logic       pdown;
	logic       active;
	logic [1:0] mode;
	logic       rng;
	logic       mute;
	logic [3:0] vol;
	logic       f_rx;
	logic       f_idle;
	logic       f_tx;
	logic       vref;
	int         bad_count;
	int         num_checks;
	logic [7:0] words [4] = '{8'h3F, 8'h5A, 8'hA5, 8'hC0};
	spcp_host spcp_host_i (.o_sclk(sclk), .o_sdata(sdata), .o_strobe(strobe));
	spcp_port spcp_port_i (.I_CLK(clk), .I_RESETN(rst_n), .I_SCLK(sclk), .I_SDATA(sdata),
		.I_WORD_LATCH_STROBE(strobe), .I_CLEAR_N(clear_n), .I_POWER_DOWN_INPUT(pdown),
		.O_ACTIVE(active), .O_MODE_SELECT(mode), .O_RANGE_SELECT(rng), .O_MIC_MUTE(mute),
		.O_VOLUME_LEVEL(vol), .O_FORCE_RX(f_rx), .O_FORCE_IDLE(f_idle), .O_FORCE_TX(f_tx),
		.O_MID_SUPPLY_REFERENCE(vref));
	// Compare and count
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Held fields and mode decode against one word
	task automatic chk_word(input logic [7:0] w);
		logic [2:0] f;
		f = (w[7:6] == 2'h0) ? 3'h0 : 3'h1 << (w[7:6] - 2'h1);
		check("fields", {mode, rng, mute, vol}, w);
		check("force", {5'h00, f_tx, f_idle, f_rx}, {5'h00, f});
	endtask
	// Verdict and end of run
	task automatic end_of_test();
		$display("Checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// System clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard
	initial begin
		#200000;
		bad_count++;
		end_of_test();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		clear_n = 1'b1;
		pdown = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk_word(8'h00);
		check("ref_active", {6'h00, vref, active}, 8'h03);
		foreach (words[k]) begin
			spcp_host_i.send(words[k]);
			chk_word(words[k]);
		end
		// Fields hold while the next word shifts in
		fork
			spcp_host_i.send(8'h12);
			#150 chk_word(8'hC0);
		join
		chk_word(8'h12);
		// Latch during clear is ignored
		@(posedge clk) clear_n <= 1'b0;
		spcp_host_i.send(8'h9C);
		chk_word(8'h00);
		@(posedge clk) clear_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk_word(8'h00);
		// Power-down zeroes the word but keeps the reference
		spcp_host_i.send(8'h9C);
		chk_word(8'h9C);
		@(posedge clk) pdown <= 1'b1;
		repeat (6) @(posedge clk);
		chk_word(8'h00);
		check("ref_active", {6'h00, vref, active}, 8'h02);
		@(posedge clk) pdown <= 1'b0;
		spcp_host_i.send(8'h47);
		chk_word(8'h47);
		end_of_test();
	end
endmodule // spcp_port_bench
